// [bench/uart_infrared_mode_switch_halt_test.sv]
// testbench: mode access halt, resume read and held data
`timescale 1ns/1ps
`default_nettype none
module uart_infrared_mode_switch_halt_test;
  localparam int DIV = 16;
  logic i_clk;
  logic i_nrst;
  uimh_pkg::uimh_wb_req_t req;
  uimh_pkg::uimh_wb_rsp_t rsp;
  logic tx;
  logic halted;
  logic halted1;
  logic halted2;
  logic irq;
  logic [7:0] rx_byte;
  logic [7:0] rx_count;
  logic [31:0] rd;
  int num_errors = 0;
  int checks_done = 0;
  uimh_pkg::uimh_mode_t safe[2] = '{uimh_pkg::UIMH_MODE_ASYNC, uimh_pkg::UIMH_MODE_CONS_IR};
  uimh_pkg::uimh_mode_t ir[3] = '{uimh_pkg::UIMH_MODE_SLOW_IR, uimh_pkg::UIMH_MODE_MED_IR,
    uimh_pkg::UIMH_MODE_FAST_IR};
  uimh_top #(.INSTANCE(uimh_pkg::INST_THIRD), .BIT_DIV(DIV)) u_uimh_top (.i_clk(i_clk),
    .i_nrst(i_nrst), .i_ce(1'b1), .i_wb(req), .o_wb(rsp), .o_tx(tx), .o_halted(halted),
    .o_irq(irq));
  // first instance shares the bus and must never halt
  uimh_top #(.INSTANCE(uimh_pkg::INST_FIRST), .BIT_DIV(DIV)) u_uimh_top_first (.i_clk(i_clk),
    .i_nrst(i_nrst), .i_ce(1'b1), .i_wb(req), .o_wb(), .o_tx(), .o_halted(halted1), .o_irq());
  // second instance is not halt capable either and must never halt
  uimh_top #(.INSTANCE(uimh_pkg::INST_SECOND), .BIT_DIV(DIV)) u_uimh_top_second (.i_clk(i_clk),
    .i_nrst(i_nrst), .i_ce(1'b1), .i_wb(req), .o_wb(), .o_tx(), .o_halted(halted2), .o_irq());
  uimh_ir_rx #(.BIT_DIV(DIV)) u_uimh_ir_rx (.i_clk(i_clk), .i_tx(tx), .o_byte(rx_byte),
    .o_count(rx_count));
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge i_clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: adr, dat: dat};
    do begin
      @(posedge i_clk);
      n++;
    end while (rsp.ack !== 1'b1 && n < 50);
    rd = rsp.dat;
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
    if (n >= 50) chk("ack", 32'h0, 32'h1);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  initial begin
    #(40 * 20000);
    num_errors++;
    report_and_stop();
  end
  initial begin
    req = '0;
    i_nrst = 1'b0;
    repeat (20) @(posedge i_clk);
    i_nrst <= 1'b1;
    settle(1);
    chk("tx", {31'h0, tx}, 32'h1);
    wb(1'b0, uimh_pkg::OFF_CONFIG, 32'h0);
    chk("config", rd, {24'h0, uimh_pkg::CONFIG_RST});
    wb(1'b0, 8'h1C, 32'h0);
    chk("unmapped", rd, 32'h0);
    $display("reset test done");
    for (int i = 0; i < 2; i++) begin
      wb(1'b1, uimh_pkg::OFF_MODE, 32'(safe[i]));
      wb(1'b0, uimh_pkg::OFF_MODE, 32'h0);
      chk("safe mode", rd, 32'(safe[i]));
      settle(2);
      chk("safe halt", {31'h0, halted}, 32'h0);
    end
    $display("safe mode test done");
    wb(1'b1, uimh_pkg::OFF_IRQ_MASK, 32'h1 << uimh_pkg::IRQ_HALT);
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, uimh_pkg::OFF_MODE, 32'(uimh_pkg::UIMH_MODE_ASYNC));
      wb(1'b0, uimh_pkg::OFF_RESUME, 32'h0);
      wb(1'b1, uimh_pkg::OFF_IRQ_STAT, 32'h7);
      wb(1'b1, uimh_pkg::OFF_MODE, 32'(ir[i]));
      settle(2 * uimh_pkg::SETTLE_CYC);
      chk("switch halt", {31'h0, halted}, 32'h0);
      wb(1'b0, uimh_pkg::OFF_MODE, 32'h0);
      chk("ir mode", rd, 32'(ir[i]));
      settle(2);
      chk("ir halt", {31'h0, halted}, 32'h1);
      chk("first halt", {31'h0, halted1}, 32'h0);
      chk("second halt", {31'h0, halted2}, 32'h0);
      chk("irq", {31'h0, irq}, 32'h1);
      wb(1'b0, uimh_pkg::OFF_RESUME, 32'h0);
      settle(2);
      chk("resume", {31'h0, halted}, 32'h0);
      wb(1'b1, uimh_pkg::OFF_IRQ_STAT, 32'h1 << uimh_pkg::IRQ_HALT);
      settle(1);
      chk("irq clear", {31'h0, irq}, 32'h0);
    end
    $display("ir mode test done");
    // halt first so the frame never starts mid-halt
    wb(1'b0, uimh_pkg::OFF_MODE, 32'h0);
    wb(1'b1, uimh_pkg::OFF_TXDATA, 32'h0000_00A5);
    // a second byte while one is pending must be refused
    wb(1'b1, uimh_pkg::OFF_TXDATA, 32'h0000_005A);
    settle(DIV * 12);
    chk("halted frames", {24'h0, rx_count}, 32'h0);
    wb(1'b0, uimh_pkg::OFF_CONFIG, 32'h0);
    chk("held config", rd, {24'h0, uimh_pkg::CONFIG_RST});
    wb(1'b0, uimh_pkg::OFF_STATUS, 32'h0);
    chk("status", rd, (32'h1 << uimh_pkg::ST_PEND) | (32'h1 << uimh_pkg::ST_HALT));
    wb(1'b0, uimh_pkg::OFF_TXDATA, 32'h0);
    chk("held txdata", rd, 32'h0000_00A5);
    wb(1'b0, uimh_pkg::OFF_RESUME, 32'h0);
    settle(DIV * 12);
    chk("frames", {24'h0, rx_count}, 32'h1);
    chk("held byte", {24'h0, rx_byte}, 32'h0000_00A5);
    wb(1'b0, uimh_pkg::OFF_IRQ_STAT, 32'h0);
    chk("irq stat", rd, (32'h1 << uimh_pkg::IRQ_HALT) | (32'h1 << uimh_pkg::IRQ_RESUME) |
      (32'h1 << uimh_pkg::IRQ_TXDONE));
    $display("held data test done");
    report_and_stop();
  end
endmodule
`default_nettype wire

// [bench/uimh_ir_rx.sv]
// infrared transceiver model: decodes frames seen on the serial line
`timescale 1ns/1ps
`default_nettype none
module uimh_ir_rx #(
  parameter int BIT_DIV = 16
) (
  input wire logic i_clk,
  input wire logic i_tx,
  output logic [7:0] o_byte,
  output logic [7:0] o_count
);
  initial begin
    o_byte = 8'h00;
    o_count = 8'h00;
    forever begin
      @(negedge i_tx);
      // sample mid-bit; a frozen frame would decode wrongly, as on a real link
      repeat (BIT_DIV / 2) @(posedge i_clk);
      if (i_tx === 1'b0) begin
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_DIV) @(posedge i_clk);
          o_byte[i] = i_tx;
        end
        repeat (BIT_DIV) @(posedge i_clk);
        o_count = o_count + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// [hdl/uimh_top.sv]
// infrared uart transmitter with false-underrun halt and resume read
//
// Decided for this implementation: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module uimh_top #(
  parameter int INSTANCE = uimh_pkg::INST_THIRD,
  parameter int BIT_DIV = 16
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire uimh_pkg::uimh_wb_req_t i_wb,
  output uimh_pkg::uimh_wb_rsp_t o_wb,
  output logic o_tx,
  output logic o_halted,
  output logic o_irq
);
  localparam bit HALT_CAPABLE = (INSTANCE == uimh_pkg::INST_THIRD);

  logic [2:0] mode_r;
  logic [7:0] config_r;
  logic [7:0] txbuf_r;
  logic pend_r;
  logic halted_r;
  logic [uimh_pkg::IRQ_W-1:0] irq_stat_r;
  logic [uimh_pkg::IRQ_W-1:0] irq_mask_r;
  logic ack_r;
  logic [31:0] rdat_r;
  logic [7:0] shift_r;
  logic [3:0] bitcnt_r;
  logic [15:0] divcnt_r;
  logic busy_r;
  logic tx_r;

  logic req;
  logic wr;
  logic rd;
  logic mode_access;
  logic affected_mode;
  logic false_underrun;
  logic resume_rd;
  logic tx_done;
  logic [uimh_pkg::IRQ_W-1:0] irq_set;

  assign req = i_wb.cyc && i_wb.stb && !ack_r;
  assign wr = req && i_wb.we;
  assign rd = req && !i_wb.we;
  assign mode_access = req && (i_wb.adr == uimh_pkg::OFF_MODE);
  // only the slow, medium and fast infrared framings use the glitchy underrun path; consumer infrared does not
  assign affected_mode = (mode_r == uimh_pkg::UIMH_MODE_SLOW_IR) ||
                         (mode_r == uimh_pkg::UIMH_MODE_MED_IR) ||
                         (mode_r == uimh_pkg::UIMH_MODE_FAST_IR);
  assign false_underrun = i_ce && mode_access && HALT_CAPABLE && affected_mode;
  assign resume_rd = i_ce && rd && (i_wb.adr == uimh_pkg::OFF_RESUME);
  assign tx_done = busy_r && (divcnt_r == 16'h0000) && (bitcnt_r == 4'h0) && !halted_r;

  // bus answer: ack one cycle after the request, dropped the next cycle
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ack_r <= 1'b0;
    end else if (i_ce) begin
      ack_r <= req;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdat_r <= uimh_pkg::NONE_DATA;
    end else if (i_ce && rd) begin
      case (i_wb.adr)
        uimh_pkg::OFF_MODE: rdat_r <= {29'h0000_0000, mode_r};
        uimh_pkg::OFF_STATUS: rdat_r <= {29'h0000_0000, pend_r, busy_r, halted_r};
        uimh_pkg::OFF_IRQ_STAT: rdat_r <= {29'h0000_0000, irq_stat_r};
        uimh_pkg::OFF_IRQ_MASK: rdat_r <= {29'h0000_0000, irq_mask_r};
        uimh_pkg::OFF_TXDATA: rdat_r <= {24'h00_0000, txbuf_r};
        uimh_pkg::OFF_CONFIG: rdat_r <= {24'h00_0000, config_r};
        default: rdat_r <= uimh_pkg::NONE_DATA;
      endcase
    end
  end

  assign o_wb.ack = ack_r;
  assign o_wb.dat = rdat_r;

  // configuration held regardless of halt
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mode_r <= uimh_pkg::UIMH_MODE_OFF;
      config_r <= uimh_pkg::CONFIG_RST;
      irq_mask_r <= '0;
    end else if (i_ce && wr && i_wb.sel[0]) begin
      case (i_wb.adr)
        uimh_pkg::OFF_MODE: mode_r <= i_wb.dat[uimh_pkg::MODE_W-1:0];
        uimh_pkg::OFF_CONFIG: config_r <= i_wb.dat[7:0];
        uimh_pkg::OFF_IRQ_MASK: irq_mask_r <= i_wb.dat[uimh_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // halt: set by false underrun, cleared only by resume read; set wins
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      halted_r <= 1'b0;
    end else if (false_underrun) begin
      halted_r <= 1'b1;
    end else if (resume_rd) begin
      halted_r <= 1'b0;
    end
  end

  // pending byte kept while halted
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      txbuf_r <= 8'h00;
      pend_r <= 1'b0;
    end else if (i_ce) begin
      if (wr && i_wb.sel[0] && (i_wb.adr == uimh_pkg::OFF_TXDATA) && !pend_r) begin
        txbuf_r <= i_wb.dat[7:0];
        pend_r <= 1'b1;
      end else if (pend_r && !busy_r && !halted_r && mode_r != uimh_pkg::UIMH_MODE_OFF) begin
        pend_r <= 1'b0;
      end
    end
  end

  // serializer freezes in place while halted
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      busy_r <= 1'b0;
      shift_r <= 8'h00;
      bitcnt_r <= 4'h0;
      divcnt_r <= 16'h0000;
      tx_r <= 1'b1;
    end else if (i_ce && !halted_r) begin
      if (!busy_r) begin
        if (pend_r && mode_r != uimh_pkg::UIMH_MODE_OFF) begin
          busy_r <= 1'b1;
          shift_r <= txbuf_r;
          bitcnt_r <= 4'h9;
          divcnt_r <= 16'(BIT_DIV - 1);
          tx_r <= 1'b0;
        end
      end else if (divcnt_r != 16'h0000) begin
        divcnt_r <= divcnt_r - 16'h0001;
      end else if (bitcnt_r == 4'h0) begin
        busy_r <= 1'b0;
      end else begin
        divcnt_r <= 16'(BIT_DIV - 1);
        bitcnt_r <= bitcnt_r - 4'h1;
        tx_r <= (bitcnt_r == 4'h1) ? 1'b1 : shift_r[0];
        shift_r <= {1'b0, shift_r[7:1]};
      end
    end
  end

  assign irq_set = {tx_done && i_ce, resume_rd && halted_r, false_underrun && !halted_r};

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_stat_r <= '0;
    end else begin
      if (i_ce && wr && i_wb.sel[0] && (i_wb.adr == uimh_pkg::OFF_IRQ_STAT)) begin
        irq_stat_r <= (irq_stat_r & ~i_wb.dat[uimh_pkg::IRQ_W-1:0]) | irq_set;
      end else begin
        irq_stat_r <= irq_stat_r | irq_set;
      end
    end
  end

  assign o_irq = |(irq_stat_r & irq_mask_r);
  assign o_tx = tx_r;
  assign o_halted = halted_r;

  property p_halt_on_access;
    @(posedge i_clk) disable iff (!i_nrst)
      false_underrun |=> halted_r;
  endproperty
  a_halt_on_access: assert property (p_halt_on_access) else $error("no halt");

  property p_only_ir_modes;
    @(posedge i_clk) disable iff (!i_nrst)
      $rose(halted_r) |-> $past(affected_mode);
  endproperty
  a_only_ir_modes: assert property (p_only_ir_modes) else $error("halt outside ir");

  property p_async_cons_clean;
    @(posedge i_clk) disable iff (!i_nrst)
      (mode_access && !affected_mode && !halted_r) |=> !halted_r;
  endproperty
  a_async_cons_clean: assert property (p_async_cons_clean) else $error("bad halt");

  property p_instance_immune;
    @(posedge i_clk) disable iff (!i_nrst)
      !HALT_CAPABLE |-> !halted_r;
  endproperty
  a_instance_immune: assert property (p_instance_immune) else $error("immune halted");

  sequence s_resume_read;
    resume_rd && !false_underrun && halted_r;
  endsequence
  property p_resume;
    @(posedge i_clk) disable iff (!i_nrst)
      s_resume_read |=> !halted_r ##1 o_wb.ack == 1'b0;
  endproperty
  a_resume: assert property (p_resume) else $error("no resume");

  property p_hold_data;
    @(posedge i_clk) disable iff (!i_nrst)
      (halted_r && $past(halted_r)) |-> ($stable(shift_r) && $stable(bitcnt_r) && $stable(tx_r));
  endproperty
  a_hold_data: assert property (p_hold_data) else $error("state moved");

  property p_hold_pend;
    @(posedge i_clk) disable iff (!i_nrst)
      (halted_r && pend_r) |=> pend_r;
  endproperty
  a_hold_pend: assert property (p_hold_pend) else $error("pending lost");

  property p_ack_pulse;
    @(posedge i_clk) disable iff (!i_nrst)
      (req && i_ce) |=> o_wb.ack ##1 !o_wb.ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack shape");

  property p_irq_halt;
    @(posedge i_clk) disable iff (!i_nrst)
      (false_underrun && !halted_r) |=> irq_stat_r[uimh_pkg::IRQ_HALT];
  endproperty
  a_irq_halt: assert property (p_irq_halt) else $error("halt irq missing");
endmodule
`default_nettype wire

// [pkg/uimh_pkg.sv]
// package: register map, mode codes and timing for the infrared halt block
package uimh_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_RESUME = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFF_TXDATA = 8'h14;
  localparam logic [7:0] OFF_CONFIG = 8'h18;
  localparam int MODE_W = 3;
  localparam int IRQ_W = 3;
  localparam int IRQ_HALT = 0;
  localparam int IRQ_RESUME = 1;
  localparam int IRQ_TXDONE = 2;
  localparam int ST_HALT = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_PEND = 2;
  localparam int INST_FIRST = 1;
  localparam int INST_SECOND = 2;
  localparam int INST_THIRD = 3;
  localparam int SETTLE_CYC = 5;
  localparam logic [7:0] CONFIG_RST = 8'h10;
  localparam logic [31:0] NONE_DATA = 32'h0000_0000;
  typedef enum logic [2:0] {
    UIMH_MODE_ASYNC = 3'h0,
    UIMH_MODE_SLOW_IR = 3'h1,
    UIMH_MODE_MED_IR = 3'h4,
    UIMH_MODE_FAST_IR = 3'h5,
    UIMH_MODE_CONS_IR = 3'h6,
    UIMH_MODE_OFF = 3'h7
  } uimh_mode_t;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [ADDR_W-1:0] adr;
    logic [31:0] dat;
  } uimh_wb_req_t;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } uimh_wb_rsp_t;
endpackage
